// ===== align_cfg_pkg.sv
// Register map, field layout and reset values for the alignment and requantizer configuration bank
package align_cfg_pkg;
  localparam logic [7:0] ALIGN_CONTROL_ADDR = 8'h3A;
  localparam logic [7:0] REQUANT_CONTROL_ADDR = 8'h3C;
  localparam logic [7:0] BAND_TUNING_ADDR = 8'h3E;
  localparam logic [7:0] PIN_CONTROL_ADDR = 8'h59;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  // Field positions
  localparam int MASTER_EN_BIT = 0;
  localparam int DIV_ALIGN_EN_BIT = 1;
  localparam int NEXT_ONLY_BIT = 2;
  localparam int REQUANT_EN_BIT = 0;
  localparam int MODE_LSB = 1;
  localparam int MODE_MSB = 3;
  localparam int EDGE_POL_BIT = 0;
  localparam int SENSE_EDGE_BIT = 1;
  localparam int TUNE_MSB = 5;
  localparam int TUNE_LSB = 0;
  // Writable masks; reserved bits read zero
  localparam logic [7:0] ALIGN_CONTROL_MASK = 8'h07;
  localparam logic [7:0] REQUANT_CONTROL_MASK = 8'h0F;
  localparam logic [7:0] BAND_TUNING_MASK = 8'h3F;
  localparam logic [7:0] PIN_CONTROL_MASK = 8'h03;
  // Band width modes and valid tuning word counts
  localparam logic [2:0] MODE_22PCT = 3'h0;
  localparam logic [2:0] MODE_33PCT = 3'h1;
  localparam logic [5:0] TUNING_COUNT_22PCT = 6'h39;
  localparam logic [5:0] TUNING_COUNT_33PCT = 6'h22;
  // Band edge step, tenths of a percent of sample rate per tuning increment
  localparam logic [9:0] STEP_PERMILLE = 10'h005;
endpackage

// ===== align_and_requantizer_config.sv
// Alignment pulse qualification and noise shaping requantizer configuration registers
`timescale 1ns/100ps

// Functional notes
// RULE_01: Master enable low disables all alignment pulse handling.
// RULE_02: Pulses reach divider only when divider enable and master enable high.
// RULE_03: Next-pulse-only mode passes first pulse, ignores later ones.
// RULE_04: Next-pulse-only clears divider enable after aligning; software re-arms.
// RULE_05: Mode 000 selects 22 percent band, 001 selects 33 percent.
// RULE_06: Requantizer enable one processes data, zero bypasses it.
// RULE_07: Tuning word valid below 57 in 22 percent, 34 in 33 percent.
// RULE_08: Each tuning increment moves band edges 0.5 percent of sample rate.
// RULE_09: Sensitivity zero responds to level, one responds to an edge.
// RULE_10: Edge polarity zero selects falling, one selects rising edges.
// RULE_11: Upper reserved bits of all four registers read zero, ignore writes.
// RULE_12: Alignment pin synchronised before level or edge detection.
module align_and_requantizer_config
  import align_cfg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic align_pin,
  output logic [7:0] reg_rdata,
  output logic divider_align,
  output logic requant_enable,
  output logic [2:0] band_width_mode,
  output logic [5:0] band_tuning_word,
  output logic tuning_valid,
  output logic [9:0] band_edge_offset
);

  // Configuration registers and their next values
  logic [7:0] align_control;
  logic [7:0] requantizer_control;
  logic [7:0] requantizer_band_tuning;
  logic [7:0] align_pin_control;
  logic [7:0] next_align_control;
  logic [7:0] next_requantizer_control;
  logic [7:0] next_requantizer_band_tuning;
  logic [7:0] next_align_pin_control;

  // Pin synchroniser and qualified event
  logic pin_meta;
  logic pin_sync;
  logic pin_prev;
  logic align_event;

  // Next values of the registered outputs
  logic [7:0] next_reg_rdata;
  logic next_divider_align;
  logic next_requant_enable;
  logic [2:0] next_band_width_mode;
  logic [5:0] next_band_tuning_word;
  logic next_tuning_valid;
  logic [9:0] next_band_edge_offset;

  // Tuning word validity for the selected band mode
  function automatic logic word_valid(input logic [2:0] mode, input logic [5:0] word);
    logic ok;
    ok = 1'b0;
    // Reserved mode codes never give a valid word
    unique case (mode)
      MODE_22PCT: ok = (word < TUNING_COUNT_22PCT);
      MODE_33PCT: ok = (word < TUNING_COUNT_33PCT);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // Band mode field of the requantizer control register
  function automatic logic [2:0] mode_field(input logic [7:0] ctrl);
    return ctrl[MODE_MSB:MODE_LSB];
  endfunction

  // Tuning word field of the band tuning register
  function automatic logic [5:0] tune_field(input logic [7:0] tune);
    return tune[TUNE_MSB:TUNE_LSB];
  endfunction

  // Band edge offset, tenths of a percent of sample rate
  function automatic logic [9:0] edge_offset(input logic [5:0] word);
    return 10'(word * STEP_PERMILLE);
  endfunction

  // Register read mux
  function automatic logic [7:0] read_reg(input logic [7:0] addr, input logic [7:0] a, input logic [7:0] r,
                                          input logic [7:0] t, input logic [7:0] p);
    logic [7:0] val;
    val = READ_UNMAPPED;
    unique case (addr)
      ALIGN_CONTROL_ADDR: val = a;
      REQUANT_CONTROL_ADDR: val = r;
      BAND_TUNING_ADDR: val = t;
      PIN_CONTROL_ADDR: val = p;
      default: val = READ_UNMAPPED;
    endcase
    return val;
  endfunction

  // Pin edge and level qualification on the synchronised pin
  always_comb
  begin
    align_event = 1'b0;
    // RULE_09 level or edge
    if (!align_pin_control[SENSE_EDGE_BIT])
      align_event = pin_sync;
    // RULE_10 edge polarity
    else if (align_pin_control[EDGE_POL_BIT])
      align_event = pin_sync & ~pin_prev;
    else
      align_event = ~pin_sync & pin_prev;
  end

  // Next register values and divider pulse
  always_comb
  begin
    next_align_control = align_control;
    next_requantizer_control = requantizer_control;
    next_requantizer_band_tuning = requantizer_band_tuning;
    next_align_pin_control = align_pin_control;
    next_divider_align = 1'b0;
    if (reg_wr)
    begin
      // RULE_11 reserved bits masked
      unique case (reg_addr)
        ALIGN_CONTROL_ADDR: next_align_control = reg_wdata & ALIGN_CONTROL_MASK;
        REQUANT_CONTROL_ADDR: next_requantizer_control = reg_wdata & REQUANT_CONTROL_MASK;
        BAND_TUNING_ADDR: next_requantizer_band_tuning = reg_wdata & BAND_TUNING_MASK;
        PIN_CONTROL_ADDR: next_align_pin_control = reg_wdata & PIN_CONTROL_MASK;
        default: next_align_pin_control = align_pin_control;
      endcase
    end

    // Alignment gating and one-shot disarm
    // RULE_01 RULE_02 gate by both enables
    if (align_control[MASTER_EN_BIT] && align_control[DIV_ALIGN_EN_BIT] && align_event)
    begin
      next_divider_align = 1'b1;
      // RULE_03 RULE_04 one-shot self clear, wins over write
      if (align_control[NEXT_ONLY_BIT])
        next_align_control[DIV_ALIGN_EN_BIT] = 1'b0;
    end
  end

  // Derived requantizer outputs
  always_comb
  begin
    // Read returns post-write values; holds otherwise
    next_reg_rdata = reg_rd ? read_reg(reg_addr, next_align_control, next_requantizer_control,
                                       next_requantizer_band_tuning, next_align_pin_control) : reg_rdata;
    // RULE_06 requantizer enable
    next_requant_enable = next_requantizer_control[REQUANT_EN_BIT];
    // RULE_05 band mode field
    next_band_width_mode = mode_field(next_requantizer_control);
    next_band_tuning_word = tune_field(next_requantizer_band_tuning);
    // RULE_07 validity per mode
    next_tuning_valid = word_valid(next_band_width_mode, next_band_tuning_word);
    // RULE_08 half-percent steps
    next_band_edge_offset = edge_offset(next_band_tuning_word);
  end

  // Configuration registers; writes and self-clear already merged
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      align_control <= REG_RESET;
      requantizer_control <= REG_RESET;
      requantizer_band_tuning <= REG_RESET;
      align_pin_control <= REG_RESET;
    end
    else
    begin
      align_control <= next_align_control;
      requantizer_control <= next_requantizer_control;
      requantizer_band_tuning <= next_requantizer_band_tuning;
      align_pin_control <= next_align_pin_control;
    end
  end

  // Output flops; reset values follow the reset register contents
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      reg_rdata <= READ_UNMAPPED;
      divider_align <= 1'b0;
      requant_enable <= REG_RESET[REQUANT_EN_BIT];
      band_width_mode <= mode_field(REG_RESET);
      band_tuning_word <= tune_field(REG_RESET);
      tuning_valid <= word_valid(mode_field(REG_RESET), tune_field(REG_RESET));
      band_edge_offset <= edge_offset(tune_field(REG_RESET));
    end
    else
    begin
      reg_rdata <= next_reg_rdata;
      divider_align <= next_divider_align;
      requant_enable <= next_requant_enable;
      band_width_mode <= next_band_width_mode;
      band_tuning_word <= next_band_tuning_word;
      tuning_valid <= next_tuning_valid;
      band_edge_offset <= next_band_edge_offset;
    end
  end

  // Pin synchroniser; only the second flop reads the first
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_prev <= 1'b0;
    end
    else
    begin
      // RULE_12 two-flop synchroniser
      pin_meta <= align_pin;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

endmodule

// ===== align_cfg_checker.sv
// Concurrent checks on the configuration bank ports
`timescale 1ns/100ps
module align_cfg_checker
  import align_cfg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic align_pin,
  input wire logic divider_align,
  input wire logic [7:0] reg_rdata,
  input wire logic requant_enable,
  input wire logic [2:0] band_width_mode,
  input wire logic [5:0] band_tuning_word,
  input wire logic tuning_valid,
  input wire logic [9:0] band_edge_offset
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_off; band_edge_offset == 10'(band_tuning_word) * 10'h005; endproperty
  a_off: assert property (p_off) else $error("offset wrong");
  property p_val; tuning_valid == (band_width_mode == 3'h0 ? band_tuning_word < 6'h39 :
    band_width_mode == 3'h1 && band_tuning_word < 6'h22); endproperty
  a_val: assert property (p_val) else $error("valid wrong");
  property p_ctl; reg_wr && reg_addr == 8'h3C |=> 8'({band_width_mode, requant_enable}) == ($past(reg_wdata) & 8'h0F);
  endproperty
  a_ctl: assert property (p_ctl) else $error("control write");
  property p_tw; reg_wr && reg_addr == 8'h3E |=> 8'(band_tuning_word) == ($past(reg_wdata) & 8'h3F); endproperty
  a_tw: assert property (p_tw) else $error("tuning write");
  property p_twh; !(reg_wr && reg_addr == 8'h3E) |=> $stable(band_tuning_word); endproperty
  a_twh: assert property (p_twh) else $error("tuning changed");
  property p_rdh; !reg_rd |=> $stable(reg_rdata); endproperty
  a_rdh: assert property (p_rdh) else $error("rdata changed");
  property p_unm; reg_rd && !(reg_addr inside {8'h3A, 8'h3C, 8'h3E, 8'h59}) |=> reg_rdata == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read");
  property p_res; reg_rd && reg_addr == 8'h3A |=> reg_rdata[7:3] == 5'h00; endproperty
  a_res: assert property (p_res) else $error("reserved bits");
  property p_pin; divider_align |-> $past(align_pin, 3) || $past(align_pin, 4); endproperty
  a_pin: assert property (p_pin) else $error("divider pulse without pin activity");
endmodule
bind align_and_requantizer_config align_cfg_checker chk_i (
  .sys_clk(sys_clk),
  .rst_n(rst_n),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .align_pin(align_pin),
  .divider_align(divider_align),
  .reg_rdata(reg_rdata),
  .requant_enable(requant_enable),
  .band_width_mode(band_width_mode),
  .band_tuning_word(band_tuning_word),
  .tuning_valid(tuning_valid),
  .band_edge_offset(band_edge_offset)
);

// ===== align_and_requantizer_config_tb_top.sv
// Testbench for the alignment and requantizer configuration bank
`timescale 1ns/100ps
module align_and_requantizer_config_tb_top;
  import align_cfg_pkg::*;
  logic sys_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, align_pin = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic divider_align, requant_enable, tuning_valid;
  logic [2:0] band_width_mode;
  logic [5:0] band_tuning_word;
  logic [9:0] band_edge_offset;
  logic [7:0] ad [4] = '{8'h3A, 8'h3C, 8'h3E, 8'h59};
  logic [7:0] mk [4] = '{8'h07, 8'h0F, 8'h3F, 8'h03};
  int miscompares = 0, num_checks = 0, pulses = 0, lim;
  always #20 sys_clk = ~sys_clk;
  align_and_requantizer_config dut (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .align_pin(align_pin),
    .reg_rdata(reg_rdata),
    .divider_align(divider_align),
    .requant_enable(requant_enable),
    .band_width_mode(band_width_mode),
    .band_tuning_word(band_tuning_word),
    .tuning_valid(tuning_valid),
    .band_edge_offset(band_edge_offset)
  );
  // Count divider pulses where they are settled
  always @(negedge sys_clk) if (divider_align === 1'b1) pulses++;
  task automatic chk(input string n, input logic [9:0] s, input logic [9:0] e);
    num_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    @(negedge sys_clk);
    reg_wr = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1;
    @(negedge sys_clk);
    reg_rd = 0;
    chk("rdata", reg_rdata, e);
  endtask
  // Pin level held six cycles
  task automatic pin(input logic v);
    align_pin = v;
    repeat (6) @(negedge sys_clk);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    #100000;
    miscompares++;
    end_sim();
  end
  initial
  begin
    repeat (20) @(negedge sys_clk);
    rst_n = 1;
    for (int i = 0; i < 4; i++)
    begin
      rd(ad[i], 8'h00);
      wr(ad[i], 8'hFF);
      rd(ad[i], mk[i]);
    end
    rd(8'h3B, 8'h00);
    chk("valid", tuning_valid, 0);
    $display("test registers done");
    for (int m = 0; m < 2; m++)
    begin
      lim = m ? 34 : 57;
      wr(8'h3C, 8'(2 * m + 1));
      chk("mode", band_width_mode, 10'(m));
      chk("enable", requant_enable, 1);
      for (int w = lim - 1; w <= lim; w++)
      begin
        wr(8'h3E, 8'(w));
        chk("valid", tuning_valid, 10'(w < lim));
        chk("offset", band_edge_offset, 10'(w * 5));
      end
    end
    wr(8'h3C, 8'h00);
    chk("enable", requant_enable, 0);
    $display("test requantizer done");
    wr(8'h59, 8'h00);
    wr(8'h3A, 8'h03);
    pin(1);
    pin(0);
    chk("level", pulses, 6);
    wr(8'h3A, 8'h02);
    pin(1);
    pin(0);
    chk("master", pulses, 6);
    wr(8'h59, 8'h03);
    wr(8'h3A, 8'h07);
    pin(1);
    chk("first", pulses, 7);
    rd(8'h3A, 8'h05);
    pin(0);
    pin(1);
    chk("ignored", pulses, 7);
    wr(8'h3A, 8'h07);
    pin(0);
    pin(1);
    chk("rearm", pulses, 8);
    wr(8'h59, 8'h02);
    wr(8'h3A, 8'h03);
    pin(0);
    pin(1);
    pin(0);
    chk("falling", pulses, 10);
    $display("test alignment done");
    end_sim();
  end
endmodule
